// ===== design/sdm_pkg.sv
package sdm_pkg;

  // word layout: sign bit, binary point, 39 fraction bits
  localparam int WORD_W = 40;
  localparam int FRAC_W = 39;
  localparam int PROD_W = 80;
  localparam int PROD_HI = 78;
  localparam int PROD_LO = 39;
  localparam int SIGN_POS = 39;

  // operation select codes
  localparam logic [1:0] OP_ADD = 2'h0;
  localparam logic [1:0] OP_SUB = 2'h1;
  localparam logic [1:0] OP_MUL = 2'h2;
  localparam logic [1:0] OP_DIV = 2'h3;

  // special words
  localparam logic [39:0] WORD_ZERO     = 40'h00_0000_0000;
  localparam logic [39:0] WORD_MINUS_1  = 40'h80_0000_0000;
  localparam logic [39:0] WORD_LSB      = 40'h00_0000_0001;
  localparam logic [39:0] WORD_NEAR_P1  = 40'h7f_ffff_ffff;
  localparam logic [39:0] WORD_NEAR_M1  = 40'h80_0000_0001;
  localparam logic [39:0] WORD_ALL_ONES = 40'hff_ffff_ffff;
  // last-place offset between quotients of differing operand signs
  localparam logic [39:0] QUO_BIAS      = 40'h00_0000_0002;

  // divider step count, one per fraction bit
  localparam logic [5:0] DIV_STEPS = 6'h27;
  localparam logic [5:0] CNT_ZERO  = 6'h00;
  localparam logic [5:0] CNT_ONE   = 6'h01;

  typedef enum logic {
    DV_IDLE = 1'b0,
    DV_RUN  = 1'b1
  } sdm_div_state_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_DIV  = 1'b1
  } sdm_state_t;

endpackage

// ===== design/sdm_mag_div.sv
`timescale 1ns/1ps
`default_nettype none

module sdm_mag_div
  import sdm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [39:0] num_i,
  input  wire logic [39:0] den_i,
  output logic             done_o,
  output logic [38:0]      quo_o
);

  sdm_div_state_t state_r;
  sdm_div_state_t state_nxt;
  logic [39:0]    rem_r;
  logic [39:0]    rem_nxt;
  logic [39:0]    den_r;
  logic [39:0]    den_nxt;
  logic [38:0]    quo_r;
  logic [38:0]    quo_nxt;
  logic [5:0]     cnt_r;
  logic [5:0]     cnt_nxt;
  logic           done_r;
  logic           done_nxt;
  logic [40:0]    rem2;
  logic [40:0]    diff;
  logic           fits;

  // restoring step on magnitudes; one quotient bit per cycle
  always_comb begin
    rem2      = {rem_r, 1'b0};
    diff      = rem2 - {1'b0, den_r};
    fits      = (rem2 >= {1'b0, den_r});
    state_nxt = state_r;
    rem_nxt   = rem_r;
    den_nxt   = den_r;
    quo_nxt   = quo_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      DV_IDLE: begin
        if (start_i) begin
          rem_nxt   = num_i;
          den_nxt   = den_i;
          quo_nxt   = '0;
          cnt_nxt   = CNT_ZERO;
          state_nxt = DV_RUN;
        end
      end
      DV_RUN: begin
        // an oversize numerator just wraps here: such quotients are undefined
        rem_nxt = fits ? diff[39:0] : rem2[39:0];
        quo_nxt = {quo_r[37:0], fits};
        cnt_nxt = cnt_r + CNT_ONE;
        if (cnt_r == DIV_STEPS - CNT_ONE) begin
          done_nxt  = 1'b1;
          state_nxt = DV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= DV_IDLE;
      rem_r   <= '0;
      den_r   <= '0;
      quo_r   <= '0;
      cnt_r   <= CNT_ZERO;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rem_r   <= rem_nxt;
      den_r   <= den_nxt;
      quo_r   <= quo_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  assign done_o = done_r;
  assign quo_o  = quo_r;

endmodule

`default_nettype wire

// ===== design/sdm_arith_unit.sv
`timescale 1ns/1ps
`default_nettype none

module sdm_arith_unit
  import sdm_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        START_I,
  input  wire logic [1:0]  OP_I,
  input  wire logic [39:0] A_I,
  input  wire logic [39:0] B_I,
  output logic [39:0]      RESULT_O,
  output logic             DONE_O,
  output logic             BUSY_O,
  output logic             SINGULAR_O,
  output logic             NEG_O,
  output logic             ZERO_O
);

  sdm_state_t    state_r;
  sdm_state_t    state_nxt;
  logic [39:0]   res_r;
  logic [39:0]   res_nxt;
  logic          done_r;
  logic          done_nxt;
  logic          busy_r;
  logic          busy_nxt;
  logic          sing_r;
  logic          sing_nxt;
  logic          xneg_r;
  logic          xneg_nxt;
  logic          yneg_r;
  logic          yneg_nxt;
  logic          zero_r;
  logic          zero_nxt;

  logic [39:0]   sum_w;
  logic [39:0]   dif_w;
  logic [79:0]   prod_full;
  logic [39:0]   mul_w;
  logic          a_m1;
  logic          b_m1;
  logic          mul_sing;
  logic [39:0]   x_mag;
  logic [39:0]   y_mag;
  logic          y_zero;
  logic          y_m1;
  logic          eq_mag;
  logic          div_sing;
  logic [39:0]   div_sing_w;
  logic          div_go;
  logic          dv_done;
  logic [38:0]   dv_quo;
  logic [39:0]   quo_odd;
  logic [39:0]   quo_dn;
  logic [39:0]   quo_fin;
  logic          take;
  logic [39:0]   fast_res;
  logic          fast_sing;
  logic          fast_go;
  logic          fin_go;

  // adder path: plain modular sum, -1 is an ordinary operand
  always_comb begin
    sum_w = A_I + B_I;
    dif_w = A_I - B_I;
  end

  // multiplier path
  always_comb begin
    a_m1      = (A_I == WORD_MINUS_1);
    b_m1      = (B_I == WORD_MINUS_1);
    prod_full = $signed(A_I) * $signed(B_I);
    // keep the high word, sign bit at the binary point
    mul_w     = prod_full[PROD_HI:PROD_LO];
    mul_sing  = a_m1 | b_m1;
    if (a_m1 && b_m1) begin
      // known wrong product; software must steer clear
      mul_w = WORD_NEAR_M1;
    end else if (a_m1) begin
      // word 2 - y, which also equals |y| for negative y
      mul_w = WORD_ZERO - B_I;
    end else if (b_m1) begin
      mul_w = WORD_ZERO - A_I;
    end
  end

  // magnitude per bit: a bit of a negative word flips once a lower one is set
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_mag
      if (gi == 0) begin : g_lsb
        assign x_mag[gi] = A_I[gi];
        assign y_mag[gi] = B_I[gi];
      end else begin : g_upr
        assign x_mag[gi] = A_I[gi] ^ (A_I[SIGN_POS] & (|A_I[gi-1:0]));
        assign y_mag[gi] = B_I[gi] ^ (B_I[SIGN_POS] & (|B_I[gi-1:0]));
      end
    end
  endgenerate

  // divider classification: x is A_I, y is B_I
  always_comb begin
    y_zero     = (B_I == WORD_ZERO);
    y_m1       = (B_I == WORD_MINUS_1);
    eq_mag     = (x_mag == y_mag);
    div_sing   = y_zero | y_m1 | eq_mag;
    div_sing_w = WORD_ZERO;
    if (y_zero) begin
      // 2 - x - lsb is the bitwise complement of x
      div_sing_w = ~A_I;
    end else if (y_m1) begin
      if (A_I[SIGN_POS]) begin
        // x = -1 wraps to 0.111...11, same as x/x negative
        div_sing_w = A_I - WORD_LSB;
      end else begin
        div_sing_w = ~A_I;
      end
    end else if (eq_mag) begin
      // sign of the result is the opposite of the denominator's sign only
      div_sing_w = B_I[SIGN_POS] ? WORD_NEAR_P1
                                 : WORD_NEAR_M1;
    end
  end

  assign take   = (state_r == ST_IDLE) && START_I;
  assign div_go = take && (OP_I == OP_DIV) && !div_sing;

  // magnitudes are unsigned; -1 gives 2^39, which still fits
  sdm_mag_div u_div (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .start_i (div_go),
    .num_i   (x_mag),
    .den_i   (y_mag),
    .done_o  (dv_done),
    .quo_o   (dv_quo)
  );

  // general quotient: last bit forced to one, then sign handling
  always_comb begin
    quo_odd = {1'b0, dv_quo} | WORD_LSB;
    quo_dn  = quo_odd - QUO_BIAS;
    quo_fin = quo_odd;
    if (xneg_r == yneg_r) begin
      // both negative lands two lsb under both positive
      quo_fin = xneg_r ? quo_dn : quo_odd;
    end else begin
      // negative quotient magnitude is two lsb short
      quo_fin = WORD_ZERO - quo_dn;
    end
  end

  // one-cycle result for whatever op sits on the inputs, except a general quotient
  always_comb begin
    fast_res  = sum_w;
    fast_sing = 1'b0;
    unique case (OP_I)
      OP_ADD: begin
        fast_res  = sum_w;
        fast_sing = 1'b0;
      end
      OP_SUB: begin
        fast_res  = dif_w;
        fast_sing = 1'b0;
      end
      OP_MUL: begin
        fast_res  = mul_w;
        fast_sing = mul_sing;
      end
      OP_DIV: begin
        // no trap or overflow: result simply written
        fast_res  = div_sing_w;
        fast_sing = div_sing;
      end
    endcase
  end

  assign fast_go = take && ((OP_I != OP_DIV) || div_sing);
  assign fin_go  = (state_r == ST_DIV) && dv_done;

  // sequencing: idle, or waiting on the divider
  always_comb begin
    state_nxt = state_r;
    busy_nxt  = busy_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (fast_go) begin
          done_nxt = 1'b1;
        end else if (div_go) begin
          busy_nxt  = 1'b1;
          state_nxt = ST_DIV;
        end
      end
      ST_DIV: begin
        // start requests here are ignored, not queued
        if (dv_done) begin
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
    end
  end

  // zero flag is its own flop so the output needs no decode
  always_comb begin
    res_nxt = res_r;
    if (fast_go) begin
      res_nxt = fast_res;
    end else if (fin_go) begin
      res_nxt = quo_fin;
    end
    zero_nxt = (res_nxt == WORD_ZERO);
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      res_r  <= WORD_ZERO;
      zero_r <= 1'b1;
    end else begin
      res_r  <= res_nxt;
      zero_r <= zero_nxt;
    end
  end

  // a general quotient is never singular, so clear at its start
  always_comb begin
    sing_nxt = sing_r;
    if (fast_go) begin
      sing_nxt = fast_sing;
    end else if (div_go) begin
      sing_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      sing_r <= 1'b0;
    end else begin
      sing_r <= sing_nxt;
    end
  end

  // operand signs kept for the last-place fix-up when the divider ends
  always_comb begin
    xneg_nxt = xneg_r;
    yneg_nxt = yneg_r;
    if (take && (OP_I == OP_DIV)) begin
      xneg_nxt = A_I[SIGN_POS];
      yneg_nxt = B_I[SIGN_POS];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      xneg_r <= 1'b0;
      yneg_r <= 1'b0;
    end else begin
      xneg_r <= xneg_nxt;
      yneg_r <= yneg_nxt;
    end
  end

  assign RESULT_O   = res_r;
  assign DONE_O     = done_r;
  assign BUSY_O     = busy_r;
  assign SINGULAR_O = sing_r;
  assign NEG_O      = res_r[SIGN_POS];
  assign ZERO_O     = zero_r;

endmodule

`default_nettype wire

// ===== tb/sdm_arith_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none

module sdm_arith_unit_checker
  import sdm_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        START_I,
  input wire logic [1:0]  OP_I,
  input wire logic [39:0] A_I,
  input wire logic [39:0] B_I,
  input wire logic [39:0] RESULT_O,
  input wire logic        DONE_O,
  input wire logic        BUSY_O,
  input wire logic        SINGULAR_O,
  input wire logic        NEG_O,
  input wire logic        ZERO_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  logic        tk;
  logic        m1a;
  logic        m1b;
  assign tk = START_I && !BUSY_O;
  assign m1a = A_I == WORD_MINUS_1;
  assign m1b = B_I == WORD_MINUS_1;

  // x over zero is the complement of x, so its sign flips
  a_neg_sign: assert property (
    tk && OP_I == OP_DIV && B_I == WORD_ZERO |=>
    NEG_O == !$past(A_I[39])) else $error("neg flag");
  a_zero_flag: assert property (
    ZERO_O == (RESULT_O == WORD_ZERO)) else $error("zero flag");
  a_add_sum: assert property (
    tk && OP_I == OP_ADD |=>
    DONE_O && RESULT_O == $past(A_I) + $past(B_I)) else $error("add");
  a_div_zero: assert property (
    tk && OP_I == OP_DIV && B_I == WORD_ZERO |=>
    DONE_O && RESULT_O == ~$past(A_I)) else $error("div zero");
  a_div_minus: assert property (
    tk && OP_I == OP_DIV && m1b |=>
    RESULT_O == ($past(A_I[39]) ? $past(A_I) - WORD_LSB : ~$past(A_I)))
    else $error("div minus one");
  a_mul_both: assert property (
    tk && OP_I == OP_MUL && m1a && m1b |=>
    DONE_O && RESULT_O == WORD_NEAR_M1) else $error("mul both");
  // the other factor is a xor b xor -1 when only one is -1
  a_mul_one: assert property (
    tk && OP_I == OP_MUL && m1a != m1b |=>
    SINGULAR_O && RESULT_O == -($past(A_I) ^ $past(B_I) ^ WORD_MINUS_1))
    else $error("mul one");
  // done shows 40 edges after busy: 39 steps plus the hand-off
  a_div_time: assert property (
    $rose(BUSY_O) |-> BUSY_O [*8] ##33 (DONE_O && !BUSY_O))
    else $error("div time");
endmodule

bind sdm_arith_unit sdm_arith_unit_checker chk_i (.CLK_I, .RESET_N_I,
  .START_I, .OP_I, .A_I, .B_I, .RESULT_O, .DONE_O, .BUSY_O, .SINGULAR_O,
  .NEG_O, .ZERO_O);

`default_nettype wire

// ===== tb/sdm_arith_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

module sdm_arith_unit_test
  import sdm_pkg::*;
;
  localparam logic [39:0] HF = 40'h40_0000_0000;
  localparam logic [39:0] NH = 40'hc0_0000_0000;
  localparam logic [39:0] QT = 40'h20_0000_0000;
  localparam logic [39:0] MO = WORD_MINUS_1;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [39:0] a = 40'h0;
  logic [39:0] b = 40'h0;
  logic [39:0] res;
  logic        done;
  logic        busy;
  logic        zero;
  logic [39:0] x;
  logic [39:0] y;
  logic [39:0] q[$];
  logic [39:0] seed = 40'h00_0001_20c9;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  sdm_arith_unit dut (.CLK_I(clk), .RESET_N_I(rst_n), .START_I(start),
    .OP_I(op), .A_I(a), .B_I(b), .RESULT_O(res), .DONE_O(done),
    .BUSY_O(busy), .SINGULAR_O(), .NEG_O(), .ZERO_O(zero));

  function automatic logic [39:0] mag(logic [39:0] v);
    return v[39] ? -v : v;
  endfunction

  function automatic logic [39:0] rnd();
    for (int i = 0; i < 40; i++)
      seed = {seed[38:0], seed[39] ^ seed[37] ^ seed[20] ^ seed[18]};
    return seed;
  endfunction

  function automatic logic [39:0] ref_of(logic [1:0] o, logic [39:0] u,
                                         logic [39:0] v);
    logic [78:0] n;
    logic [79:0] p;
    logic [39:0] qv;
    n = {mag(u), 39'h0} / mag(v);
    p = $signed(u) * $signed(v);
    qv = {1'b0, n[38:0]} | WORD_LSB;
    case (o)
      OP_ADD: return u + v;
      OP_SUB: return u - v;
      OP_MUL:
        if (u == MO && v == MO) return WORD_NEAR_M1;
        else if (u == MO) return -v;
        else if (v == MO) return -u;
        else return p[78:39];
      default:
        if (v == WORD_ZERO) return ~u;
        else if (v == MO) return u[39] ? u - WORD_LSB : ~u;
        else if (mag(u) == mag(v)) return v[39] ? WORD_NEAR_P1 : WORD_NEAR_M1;
        else if (u[39] == v[39]) return u[39] ? qv - QUO_BIAS : qv;
        else return QUO_BIAS - qv;
    endcase
  endfunction

  task automatic chk(string nm, logic [39:0] e, logic [39:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict();
    if (q.size() != 0) bad_count++;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // held start gives back-to-back requests for one-cycle ops
  task automatic go(logic [1:0] o, logic [39:0] u, logic [39:0] v);
    start <= 1'b1;
    op <= o;
    a <= u;
    b <= v;
    q.push_back(ref_of(o, u, v));
    @(posedge clk);
  endtask

  task automatic settle();
    start <= 1'b0;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      if (q.size() == 0) break;
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1 && q.size() == 0) chk("done", 40'h0, 40'h1);
    else if (done === 1'b1) chk("result", q.pop_front(), res);
    if (done === 1'b1) chk("busy", 40'h0, {39'h0, busy});
    if (cyc == 3000) begin
      chk("timeout", 40'h0, 40'h1);
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset", WORD_LSB, {res[38:0], zero});
    go(OP_DIV, 40'h12_3456_789a, WORD_ZERO);
    go(OP_DIV, MO, WORD_ZERO);
    go(OP_DIV, WORD_ZERO, WORD_ZERO);
    go(OP_DIV, HF, HF);
    go(OP_DIV, NH, HF);
    go(OP_DIV, NH, NH);
    go(OP_DIV, HF, NH);
    go(OP_DIV, QT, MO);
    go(OP_DIV, NH, MO);
    go(OP_DIV, MO, MO);
    go(OP_DIV, WORD_ZERO, MO);
    go(OP_MUL, MO, HF);
    go(OP_MUL, HF, MO);
    go(OP_MUL, MO, WORD_ZERO);
    go(OP_MUL, MO, NH);
    go(OP_MUL, MO, MO);
    go(OP_ADD, MO, QT);
    go(OP_SUB, MO, MO);
    settle();
    $display("test singular done");
    go(OP_DIV, QT, HF);
    settle();
    go(OP_DIV, -QT, NH);
    settle();
    go(OP_DIV, -QT, HF);
    settle();
    $display("test exact quotient done");
    for (int i = 0; i < 30; i++) begin
      x = rnd();
      y = rnd();
      if (mag(x) > mag(y)) {x, y} = {y, x};
      go(seed[1:0], x, y);
      if (seed[1:0] == OP_DIV) settle();
    end
    settle();
    $display("test random done");
    print_verdict();
  end
endmodule

`default_nettype wire
